// ==== smel_pkg.sv ====
// package: shared constants for the multiturn encoder serial link
package smel_pkg;
  localparam int ST_W = 14;
  localparam int MT_W = 24;
  localparam int POS_W = 38;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] POS_W_C = 6'h26;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam int LINK_HZ_MAX = 2_000_000;
  localparam int LINK_HZ_MIN = 50_000;
  localparam int SYS_HZ = 200_000_000;
  localparam int SYS_NS = 5;
  // half period of the fastest legal master clock, in system clocks
  localparam int HALF_MIN = SYS_HZ / (2 * LINK_HZ_MAX);
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_ZERO = 12'h000;
  localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;
  localparam logic [DIV_W-1:0] HALF_CYC = DIV_W'(HALF_MIN);
  // half period of the slowest legal master clock, in system clocks
  localparam logic [DIV_W-1:0] HALF_MAX_C =
    DIV_W'(SYS_HZ / (2 * LINK_HZ_MIN));
  // monoflop in steps of TICK system clocks; it must outlast the longest
  // legal half period, or a slow burst would be split in two
  localparam int MONO_W = 8;
  localparam logic [MONO_W-1:0] MONO_CYC = 8'h20;
  localparam logic [MONO_W-1:0] MONO_ZERO = 8'h00;
  localparam logic [MONO_W-1:0] MONO_ONE = 8'h01;
  localparam int TICK_W = 6;
  localparam logic [TICK_W-1:0] TICK_ZERO = 6'h00;
  localparam logic [TICK_W-1:0] TICK_ONE = 6'h01;
  localparam logic [TICK_W-1:0] TICK_LAST = 6'h3f;
  localparam int PRESET_MS = 1;
  localparam int STORE_MS = 200;
  localparam int POWERUP_MS = 150;
  localparam int DIR_MS = 1;
  localparam int PRESET_MIN_MS = 10;
  localparam int TMR_W = 32;
  localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 32'h0000_0001;
  localparam int NS_PER_MS = 1_000_000;
  localparam int CYC_PER_MS = NS_PER_MS / SYS_NS;
  function automatic logic [POS_W-1:0] to_gray(input logic [POS_W-1:0] b);
    return b ^ (b >> 1);
  endfunction
endpackage

// ==== smel_if.sv ====
// interface: serial clock and data lines between master and encoder
`timescale 1ns/10ps
`default_nettype none
interface smel_if;
  logic sclk;
  logic sdata;
  modport encoder (input sclk, output sdata);
  modport master (output sclk, input sdata);
endinterface
`default_nettype wire

// ==== smel_encoder.sv ====
// module: encoder end, latches and shifts the position word
`timescale 1ns/10ps
`default_nettype none
// What the link requires of encoder and master
// [RULE_01] link clock 50 kHz to 2 MHz
// [RULE_02] word: up to 14 singleturn, 24 multiturn
// [RULE_03] gray or binary by variant
// [RULE_04] burst inside monoflop resends held word
// [RULE_05] burst after monoflop latches fresh word
// [RULE_06] first fall latches; msb first on rises
// [RULE_07] preset high zeroes reported position
// [RULE_08] preset value may be factory constant
// [RULE_09] master holds preset at least 10 ms
// [RULE_10] preset shows on data within 1 ms
// [RULE_11] preset then 200 ms storage busy
// [RULE_12] preset only while shaft stationary
// [RULE_13] direction high reverses counting sense
// [RULE_14] inverted sense factory default option
// [RULE_15] direction change applied within 1 ms
// [RULE_16] 150 ms power-up before valid data
// [RULE_17] monoflop constant; data idles high
module smel_encoder #(
  parameter int SINGLETURN_BITS = 14,
  parameter int MULTITURN_BITS = 24,
  parameter bit GRAY_CODE = 1'b1,
  parameter logic [smel_pkg::POS_W-1:0] PRESET_VALUE = '0,
  parameter bit DIR_INVERT = 1'b0,
  parameter logic [31:0] PRESET_CYC = 32'(smel_pkg::PRESET_MS
                                          * smel_pkg::CYC_PER_MS),
  parameter logic [31:0] STORE_CYC = 32'(smel_pkg::STORE_MS
                                         * smel_pkg::CYC_PER_MS),
  parameter logic [31:0] POWERUP_CYC = 32'(smel_pkg::POWERUP_MS
                                           * smel_pkg::CYC_PER_MS),
  parameter logic [31:0] DIR_CYC = 32'(smel_pkg::DIR_MS
                                       * smel_pkg::CYC_PER_MS)
) (
  input wire logic clk,
  input wire logic rst_n,
  smel_if.encoder link,
  input wire logic [smel_pkg::POS_W-1:0] shaft_pos,
  input wire logic preset_in,
  input wire logic dir_in,
  output logic data_valid,
  output logic store_busy
);
  localparam logic [5:0] WORD_BITS = 6'(SINGLETURN_BITS + MULTITURN_BITS);

  // system-domain state
  typedef struct packed {
    logic [1:0] pre_sync;
    logic [1:0] dir_sync;
    logic [smel_pkg::TMR_W-1:0] pre_tmr;
    logic [smel_pkg::TMR_W-1:0] store_tmr;
    logic [smel_pkg::TMR_W-1:0] pwr_tmr;
    logic [smel_pkg::TMR_W-1:0] dir_tmr;
    logic dir_eff;
    logic pre_done;
    logic [smel_pkg::POS_W-1:0] offset;
    logic [smel_pkg::POS_W-1:0] pos_word;
    logic valid;
    logic busy;
    logic [1:0] sclk_sync;
    logic sclk_seen;
    logic [smel_pkg::TICK_W-1:0] tick;
    logic [smel_pkg::MONO_W-1:0] mono;
    logic mono_run;
    logic [smel_pkg::POS_W-1:0] snap;
    logic [1:0] bit_sync;
    logic [1:0] act_sync;
    logic sdata;
  } smel_sys_s;
  smel_sys_s s_reg, s_next;

  // link-domain state: falling-edge latch and rising-edge shifter
  typedef struct packed {
    logic [smel_pkg::POS_W-1:0] word;
    logic tag;
  } smel_fall_s;
  smel_fall_s fall_reg, fall_next;
  typedef struct packed {
    logic [smel_pkg::POS_W-1:0] shreg;
    logic [smel_pkg::CNT_W-1:0] bits_left;
    logic active;
    logic tag;
    logic sdata;
  } smel_rise_s;
  smel_rise_s rise_reg, rise_next;
  // left shift that puts the msb of a narrower word on the top bit
  localparam logic [smel_pkg::CNT_W-1:0] PAD_BITS =
    smel_pkg::POS_W_C - WORD_BITS;

  logic [smel_pkg::POS_W-1:0] raw;
  logic [smel_pkg::POS_W-1:0] mask;

  always_comb begin
    mask = (smel_pkg::POS_W)'((39'h1 << WORD_BITS) - 39'h1);
    s_next = s_reg;
    s_next.pre_sync = {s_reg.pre_sync[0], preset_in};
    s_next.dir_sync = {s_reg.dir_sync[0], dir_in};
    // direction filter: change applied after a settled interval
    if (s_reg.dir_sync[1] != s_reg.dir_eff) begin
      if (s_reg.dir_tmr >= DIR_CYC - smel_pkg::TMR_ONE) begin // see [RULE_15]
        s_next.dir_eff = s_reg.dir_sync[1];
        s_next.dir_tmr = smel_pkg::TMR_ZERO;
      end else begin
        s_next.dir_tmr = s_reg.dir_tmr + smel_pkg::TMR_ONE;
      end
    end else begin
      s_next.dir_tmr = smel_pkg::TMR_ZERO;
    end
    // direction sense, optionally factory inverted
    if (s_reg.dir_eff ^ DIR_INVERT) begin // see [RULE_13] see [RULE_14]
      raw = (~shaft_pos + 38'h1) & mask;
    end else begin
      raw = shaft_pos & mask;
    end
    // preset: after the input delay, capture offset once per pulse
    if (s_reg.pre_sync[1]) begin
      if (s_reg.pre_tmr < PRESET_CYC) begin
        s_next.pre_tmr = s_reg.pre_tmr + smel_pkg::TMR_ONE;
      end else if (!s_reg.pre_done) begin
        s_next.offset = (raw - PRESET_VALUE) & mask; // see [RULE_07] [RULE_08]
        s_next.pre_done = 1'b1;
        s_next.store_tmr = STORE_CYC; // see [RULE_11]
        s_next.busy = 1'b1;
      end
    end else begin
      s_next.pre_tmr = smel_pkg::TMR_ZERO;
      s_next.pre_done = 1'b0;
    end
    if (s_reg.busy) begin
      if (s_reg.store_tmr == smel_pkg::TMR_ONE) begin
        s_next.busy = 1'b0;
      end
      s_next.store_tmr = s_reg.store_tmr - smel_pkg::TMR_ONE;
    end
    s_next.pos_word = (raw - s_reg.offset) & mask; // see [RULE_10] [RULE_02]
    if (GRAY_CODE) begin
      s_next.pos_word = smel_pkg::to_gray((raw - s_reg.offset) & mask); // see [RULE_03]
    end
    if (s_reg.pwr_tmr < POWERUP_CYC) begin // see [RULE_16]
      s_next.pwr_tmr = s_reg.pwr_tmr + smel_pkg::TMR_ONE;
    end else begin
      s_next.valid = 1'b1;
    end
    // monoflop: restarted by every synchronised link edge
    s_next.sclk_sync = {s_reg.sclk_sync[0], link.sclk};
    s_next.sclk_seen = s_reg.sclk_sync[1];
    if (s_reg.sclk_sync[1] != s_reg.sclk_seen) begin
      s_next.mono = smel_pkg::MONO_CYC; // see [RULE_06] [RULE_17]
      s_next.tick = smel_pkg::TICK_ZERO;
    end else if (s_reg.mono != smel_pkg::MONO_ZERO) begin
      s_next.tick = s_reg.tick + smel_pkg::TICK_ONE;
      if (s_reg.tick == smel_pkg::TICK_LAST) begin
        s_next.mono = s_reg.mono - smel_pkg::MONO_ONE;
      end
    end
    s_next.mono_run = (s_next.mono != smel_pkg::MONO_ZERO);
    // snapshot held still while a burst or its monoflop runs
    if (!s_reg.mono_run && s_reg.sclk_seen) begin
      s_next.snap = s_reg.pos_word; // see [RULE_05]
    end
    // data pin: link bit while a burst or monoflop runs, else high;
    // the monoflop outlasts the master's late sample of the last bit
    s_next.bit_sync = {s_reg.bit_sync[0], rise_reg.sdata};
    s_next.act_sync = {s_reg.act_sync[0], rise_reg.active};
    if (s_reg.act_sync[1] || s_reg.mono_run) begin
      s_next.sdata = s_reg.bit_sync[1];
    end else begin
      s_next.sdata = 1'b1; // see [RULE_17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      // link idles high: no false monoflop start after reset
      s_reg.sclk_sync <= 2'b11;
      s_reg.sclk_seen <= 1'b1;
      s_reg.sdata <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign data_valid = s_reg.valid;
  assign store_busy = s_reg.busy;

  // falling edge: the first fall of a burst latches the word to send;
  // snap follows pos_word up to a first fall and freezes a few system clocks after it;
  // mono_run sits still for many system clocks before it, since the master keeps the link quiet between bursts
  always_comb begin
    fall_next = fall_reg;
    if (!rise_reg.active) begin
      fall_next.tag = ~fall_reg.tag; // see [RULE_06]
      if (!s_reg.mono_run) begin
        fall_next.word = s_reg.snap << PAD_BITS; // see [RULE_05]
      end else begin
        fall_next.word = fall_reg.word; // see [RULE_04]
      end
    end
  end

  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= fall_next;
    end
  end

  // rising edge: one bit per rise, msb first, extra rises ignored
  always_comb begin
    rise_next = rise_reg;
    if (fall_reg.tag != rise_reg.tag) begin
      rise_next.tag = fall_reg.tag;
      rise_next.sdata = fall_reg.word[smel_pkg::POS_W-1]; // see [RULE_06]
      rise_next.shreg = {fall_reg.word[smel_pkg::POS_W-2:0], 1'b0};
      rise_next.bits_left = WORD_BITS - smel_pkg::CNT_ONE;
      rise_next.active = 1'b1;
    end else if (rise_reg.active) begin
      rise_next.sdata = rise_reg.shreg[smel_pkg::POS_W-1]; // see [RULE_06]
      rise_next.shreg = {rise_reg.shreg[smel_pkg::POS_W-2:0], 1'b0};
      rise_next.bits_left = rise_reg.bits_left - smel_pkg::CNT_ONE;
      rise_next.active = (rise_reg.bits_left != smel_pkg::CNT_ONE);
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      rise_reg <= '0;
      rise_reg.sdata <= 1'b1;
    end else begin
      rise_reg <= rise_next;
    end
  end

  assign link.sdata = s_reg.sdata;
endmodule // smel_encoder
`default_nettype wire

// ==== smel_master.sv ====
// module: master end, makes the serial clock and captures the word
`timescale 1ns/10ps
`default_nettype none
module smel_master (
  input wire logic clk,
  input wire logic rst_n,
  smel_if.master link,
  input wire logic start,
  input wire logic [smel_pkg::DIV_W-1:0] half_period,
  output logic [smel_pkg::POS_W-1:0] word_out,
  output logic word_done,
  output logic busy
);
  typedef enum logic [1:0] {SM_IDLE, SM_LOW, SM_HIGH} smel_state_e;
  typedef struct packed {
    smel_state_e st;
    logic [smel_pkg::DIV_W-1:0] div;
    logic [smel_pkg::CNT_W-1:0] cnt;
    logic [1:0] dsync;
    logic sclk;
    logic [smel_pkg::POS_W-1:0] shreg;
    logic [smel_pkg::POS_W-1:0] word;
    logic done;
    logic busy;
  } smel_m_s;
  smel_m_s r_reg, r_next;
  logic [smel_pkg::DIV_W-1:0] half;

  always_comb begin
    // clamp to the fastest legal rate
    half = (half_period < smel_pkg::HALF_CYC) ? smel_pkg::HALF_CYC
                                              : half_period; // see [RULE_01]
    // and to the slowest legal rate
    if (half > smel_pkg::HALF_MAX_C) begin
      half = smel_pkg::HALF_MAX_C; // see [RULE_01]
    end
    r_next = r_reg;
    r_next.dsync = {r_reg.dsync[0], link.sdata};
    r_next.done = 1'b0;
    unique case (r_reg.st)
      SM_IDLE: begin
        r_next.sclk = 1'b1;
        r_next.busy = 1'b0;
        if (start) begin
          r_next.st = SM_LOW;
          r_next.sclk = 1'b0;
          r_next.busy = 1'b1;
          r_next.div = smel_pkg::DIV_ZERO;
          r_next.cnt = smel_pkg::POS_W_C;
        end
      end
      SM_LOW: begin
        r_next.div = r_reg.div + smel_pkg::DIV_ONE;
        if (r_reg.div == half - smel_pkg::DIV_ONE) begin
          r_next.div = smel_pkg::DIV_ZERO;
          r_next.sclk = 1'b1;
          r_next.st = SM_HIGH;
        end
      end
      SM_HIGH: begin
        r_next.div = r_reg.div + smel_pkg::DIV_ONE;
        if (r_reg.div == half - smel_pkg::DIV_ONE) begin
          // sample late in high phase, past the two-stage sync
          r_next.div = smel_pkg::DIV_ZERO;
          r_next.shreg = {r_reg.shreg[smel_pkg::POS_W-2:0], r_reg.dsync[1]};
          r_next.cnt = r_reg.cnt - smel_pkg::CNT_ONE;
          if (r_reg.cnt == smel_pkg::CNT_ONE) begin
            r_next.st = SM_IDLE;
            r_next.word = {r_reg.shreg[smel_pkg::POS_W-2:0], r_reg.dsync[1]};
            r_next.done = 1'b1;
          end else begin
            r_next.sclk = 1'b0;
            r_next.st = SM_LOW;
          end
        end
      end
      default: begin
        r_next.st = SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.sclk <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.sclk = r_reg.sclk;
  assign word_out = r_reg.word;
  assign word_done = r_reg.done;
  assign busy = r_reg.busy;
endmodule // smel_master
`default_nettype wire

// ==== smel_link_checker.sv ====
// checker: timing and framing of the serial link lines
`timescale 1ns/10ps
`default_nettype none
module smel_link_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdata
);
  localparam int HMIN = smel_pkg::HALF_MIN - 1;
  localparam int HMAX = smel_pkg::SYS_HZ / (2 * smel_pkg::LINK_HZ_MIN);
  // past the monoflop the line must be back at its idle level
  localparam int IDLE = 2 * HMAX;
  logic [11:0] hcnt;
  logic [5:0] rcnt;
  logic sclk_d;
  // hcnt: clocks since the last sclk change, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt <= 12'hfff;
      rcnt <= 6'h00;
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
      if (sclk != sclk_d) begin
        hcnt <= 12'h000;
      end else if (hcnt != 12'hfff) begin
        hcnt <= hcnt + 12'h001;
      end
      if (sclk && !sclk_d) begin
        rcnt <= (rcnt == 6'h25) ? 6'h00 : rcnt + 6'h01;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence low8;
    !sclk [*8];
  endsequence
  sequence idle_entry;
    sclk && hcnt == 12'(HMAX);
  endsequence
  a_reset_sclk_high: assert property ($rose(rst_n) |-> sclk)
    else $error("sclk not high after reset");
  a_reset_data_high: assert property ($rose(rst_n) |-> sdata)
    else $error("sdata not high after reset");
  a_half_min: assert property ($changed(sclk) |-> hcnt >= HMIN)
    else $error("sclk phase shorter than minimum");
  a_half_max: assert property (!sclk && !sclk_d |-> hcnt < HMAX)
    else $error("sclk low phase longer than maximum");
  a_low_stable: assert property (
    low8 ##1 !sclk |-> $stable(sdata))
    else $error("sdata moved in sclk low phase");
  a_data_settle: assert property (
    $changed(sdata) |-> hcnt < 8 || (sdata && sclk && hcnt >= HMAX))
    else $error("sdata changed away from an sclk edge");
  a_idle_high: assert property (sclk && hcnt >= IDLE |-> sdata)
    else $error("sdata not high while idle");
  a_whole_word: assert property (idle_entry |-> rcnt == 6'h00)
    else $error("burst was not whole words");
endmodule // smel_link_checker
`default_nettype wire

// ==== ssi_multiturn_encoder_link_test.sv ====
// testbench: both link ends joined, driven from their user sides
`timescale 1ns/10ps
`default_nettype none
module ssi_multiturn_encoder_link_test;
  localparam int PW = smel_pkg::POS_W;
  typedef struct packed {
    logic [PW-1:0] pos;
    logic dir;
    logic [11:0] half;
    logic [PW-1:0] exp;
  } smel_row_s;
  logic clk;
  logic rst_n;
  logic [PW-1:0] shaft_pos;
  logic preset_in;
  logic dir_in;
  logic data_valid;
  logic store_busy;
  logic start;
  logic [11:0] half_period;
  logic [PW-1:0] word_out;
  logic word_done;
  logic busy;
  logic [PW-1:0] w;
  smel_row_s rows [5];
  int fail_count;
  int check_count;
  int cyc = 0;
  smel_if smel_if_i ();
  smel_encoder #(.PRESET_CYC(32'h0000_0014), .STORE_CYC(32'h0000_1388),
    .POWERUP_CYC(32'h0000_003c), .DIR_CYC(32'h0000_0014)) smel_encoder_i (
    .clk(clk), .rst_n(rst_n), .link(smel_if_i.encoder),
    .shaft_pos(shaft_pos), .preset_in(preset_in), .dir_in(dir_in),
    .data_valid(data_valid), .store_busy(store_busy));
  smel_master smel_master_i (.clk(clk), .rst_n(rst_n),
    .link(smel_if_i.master), .start(start), .half_period(half_period),
    .word_out(word_out), .word_done(word_done), .busy(busy));
  smel_link_checker smel_link_checker_i (.clk(clk), .rst_n(rst_n),
    .sclk(smel_if_i.sclk), .sdata(smel_if_i.sdata));
  always #2.5 clk = ~clk;
  // expected word: reversed sense negates, then gray coding
  function automatic logic [PW-1:0] code(input logic [PW-1:0] p,
                                         input logic d);
    logic [PW-1:0] v;
    v = d ? (~p + 38'h1) : p;
    return v ^ (v >> 1);
  endfunction
  function automatic smel_row_s mk(input logic [PW-1:0] p, input logic d,
                                   input logic [11:0] h);
    return '{p, d, h, code(p, d)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [PW-1:0] seen, input logic [PW-1:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic read(input logic [11:0] h, output logic [PW-1:0] q);
    int n;
    half_period = h;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (n = 0; n < 80 * h && word_done !== 1'b1; n++) begin
      tick(1);
    end
    q = word_out;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    shaft_pos = '0;
    preset_in = 1'b0;
    dir_in = 1'b0;
    start = 1'b0;
    half_period = 12'h032;
    fail_count = 0;
    check_count = 0;
    rows[0] = mk(38'h00_0000_0001, 1'b0, 12'h032);
    rows[1] = mk(38'h3f_ffff_ffff, 1'b0, 12'h032);
    rows[2] = mk(38'h12_3456_789a, 1'b0, 12'h040);
    rows[3] = mk(38'h00_0000_0001, 1'b1, 12'h032);
    rows[4] = mk(38'h20_0000_0000, 1'b1, 12'h032);
    tick(4);
    rst_n = 1'b1;
    tick(70);
    foreach (rows[i]) begin
      shaft_pos = rows[i].pos;
      dir_in = rows[i].dir;
      tick(80 * rows[i].half);
      read(rows[i].half, w);
      check(w, rows[i].exp);
    end
    // back-to-back burst inside the monoflop time repeats the held word
    shaft_pos = 38'h00_0000_0abc;
    dir_in = 1'b0;
    tick(4000);
    read(12'h032, w);
    check(w, code(38'h00_0000_0abc, 1'b0));
    shaft_pos = 38'h00_0000_0def;
    read(12'h032, w);
    check(w, code(38'h00_0000_0abc, 1'b0));
    rst_n = 1'b0;
    tick(2);
    check(PW'({smel_if_i.sclk, smel_if_i.sdata, data_valid, busy}),
          PW'(4'hc));
    rst_n = 1'b1;
    tick(2);
    check(PW'(data_valid), PW'(1'b0));
    tick(70);
    check(PW'(data_valid), PW'(1'b1));
    shaft_pos = 38'h01_2345_6789; // shaft held still
    preset_in = 1'b1; // held past the preset delay
    tick(30);
    read(12'h032, w);
    check(w, '0);
    check(PW'(store_busy), PW'(1'b1));
    preset_in = 1'b0;
    tick(4000);
    check(PW'(store_busy), PW'(1'b0));
    shaft_pos = 38'h01_2345_678e;
    tick(4000);
    read(12'h032, w);
    check(w, code(38'h00_0000_0005, 1'b0));
    give_verdict();
  end
endmodule // ssi_multiturn_encoder_link_test
`default_nettype wire
